// ---- verilog/strap_pkg.sv ----
/*
 * Shared constants and carrier types for the strap, power-control and
 * host-bus signalling block.
 * Assumes a single system clock and a synchronous active-low reset.
 */
package strap_pkg;

    // ****************************************************************
    // register map (APB byte addresses)
    // ****************************************************************
    localparam logic [11:0] DMA_CTRL_OFFSET    = 12'h000;
    localparam logic [11:0] STRAP_STAT_OFFSET  = 12'h004;
    localparam logic [11:0] SLOT_CTRL_OFFSET   = 12'h008;

    // ****************************************************************
    // field positions and resets
    // ****************************************************************
    localparam int           DMA_SEL_LSB        = 6;
    localparam int           PU_DETECT_BIT      = 5;
    localparam int           PU_MEMORY_BIT      = 4;
    localparam int           PU_IO_BIT          = 3;
    localparam logic [7:0]   DMA_CTRL_RESET     = 8'h00;
    localparam int           SLOT_PROG_BIT      = 0;
    localparam int           SLOT_PROGVCC_BIT   = 1;
    localparam int           SLOT_SUP5_BIT      = 2;
    localparam int           SLOT_SUP3_BIT      = 3;
    localparam int           SLOT_CARDRST_BIT   = 4;
    localparam int           SLOT_SPKR_BIT      = 5;
    localparam int           SLOT_TC_BIT        = 6;
    localparam logic [7:0]   SLOT_CTRL_RESET    = 8'h00;

    // ****************************************************************
    // ports and decode
    // ****************************************************************
    localparam logic [15:0]  INDEX_PORT_PRI     = 16'h03E0;
    localparam logic [15:0]  DATA_PORT_PRI      = 16'h03E1;
    localparam logic [15:0]  INDEX_PORT_SEC     = 16'h03E2;
    localparam logic [15:0]  DATA_PORT_SEC      = 16'h03E3;

    // dma request source select
    localparam logic [1:0]   DMA_SRC_NONE       = 2'h0;
    localparam logic [1:0]   DMA_SRC_INPACK     = 2'h1;
    localparam logic [1:0]   DMA_SRC_IOIS16     = 2'h2;
    localparam logic [1:0]   DMA_SRC_SPKR       = 2'h3;

    // test function select
    localparam logic [1:0]   TEST_NAND          = 2'h0;
    localparam logic [1:0]   TEST_HILO          = 2'h1;
    localparam logic [1:0]   TEST_LOHI          = 2'h2;
    localparam logic [1:0]   TEST_TRISTATE      = 2'h3;

    typedef enum {PH_IDLE, PH_ADDR, PH_CLAIM, PH_DATA, PH_REQ, PH_ACK} phase_t;

    typedef struct packed {
        logic        valid;
        logic        secondary;
        logic        testMode;
        logic [1:0]  range;
    } straps_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic        claim;
        logic        claimOe;
        logic        ready;
        logic        readyOe;
        logic [15:0] busOut;
        logic        busOe;
    } host_out_t;

    typedef struct packed {
        logic        supply5;
        logic        supply3;
        logic        progVoltage;
        logic        progFollows;
        logic        progPullup;
        logic        detectPullup;
        logic        memoryPullup;
        logic        ioPullup;
    } power_out_t;

endpackage

// ---- verilog/strap_host_signalling.sv ----
/*
 * Reset strap capture, slot power control, pull-up control and the
 * peripheral side of the multiplexed host-bus signalling.
 * Assumes every input is synchronous to clk_sys and that the far end
 * drives the command strobe and latch enable as the bus defines.
 */
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module strap_host_signalling
(
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire logic                   clkEn,
    input  wire strap_pkg::apb_req_t    apbReq,
    output strap_pkg::apb_rsp_t         apbRsp,
    input  wire logic [15:0]            muxedHostBusIn,
    input  wire logic                   addrLatchEnable,
    input  wire logic                   commandStrobeN,
    input  wire logic                   cardWaitN,
    input  wire logic                   cardSpeaker,
    input  wire logic                   cardInpackN,
    input  wire logic                   cardIois16N,
    input  wire logic                   requestPending,
    input  wire logic                   dmaTerminalCount,
    input  wire logic                   dmaIsRead,
    input  wire logic                   strapSupply5,
    input  wire logic                   strapSupply3,
    input  wire logic                   strapProgVoltage,
    input  wire logic                   strapProgFollows,
    output strap_pkg::host_out_t        hostOut,
    output strap_pkg::power_out_t       powerOut,
    output logic                        speakerToHost,
    output logic                        speakerToHostOe,
    output logic                        cardDmaRequestN,
    output logic                        cardReset,
    output logic                        cardMemWriteN,
    output logic                        cardMemReadN,
    output logic                        cardIoWriteN,
    output logic                        cardIoReadN,
    output logic                        dataPortHit,
    output logic [7:0]                  dataPortIndex,
    output logic [1:0]                  testFunction,
    output logic                        testActive
);
    import strap_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        phase_t      phase;
        straps_t     straps;
        logic        aleQ;
        logic [15:0] phase1;
        logic [15:0] phase2;
        logic [7:0]  index;
        logic [7:0]  dmaCtrl;
        logic [7:0]  slotCtrl;
        apb_rsp_t    apb;
        host_out_t   host;
        power_out_t  power;
        logic        spk;
        logic        spkOe;
        logic        dreqN;
        logic        cardRst;
        logic        memWrN;
        logic        memRdN;
        logic        ioWrN;
        logic        ioRdN;
        logic        hit;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic        aleRise;
    logic        isIo;
    logic [15:0] ioAddr;
    logic [15:0] idxPort;
    logic [15:0] datPort;
    logic        inRange;
    logic        apbWr;
    logic        apbRd;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;
        aleRise = addrLatchEnable & ~s_q.aleQ;
        isIo = ~s_q.phase1[0];
        ioAddr = {s_q.phase1[7:2], s_q.phase1[15:8], muxedHostBusIn[7:6]};
        idxPort = s_q.straps.secondary ? INDEX_PORT_SEC : INDEX_PORT_PRI;
        datPort = s_q.straps.secondary ? DATA_PORT_SEC : DATA_PORT_PRI;
        inRange = (s_q.index[7:6] == s_q.straps.range);
        apbWr = apbReq.psel & apbReq.penable & apbReq.pwrite;
        apbRd = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
        s_d.aleQ = addrLatchEnable;

        // strap capture on first enabled cycle after reset release
        if (!s_q.straps.valid)
        begin
            s_d.straps.valid = 1'b1;
            s_d.straps.secondary = strapSupply5;
            s_d.straps.testMode = strapSupply3;
            s_d.straps.range = {~strapProgFollows, ~strapProgVoltage};
        end

        // bus phases
        s_d.hit = 1'b0;
        case (s_q.phase)
            PH_IDLE:
            begin
                s_d.host.claimOe = 1'b0;
                s_d.host.readyOe = 1'b0;
                if (!addrLatchEnable && requestPending)
                begin
                    s_d.host.claim = 1'b0;
                    s_d.host.claimOe = 1'b1;
                    s_d.phase = PH_REQ;
                end
                else if (!addrLatchEnable)
                begin
                    s_d.phase1 = muxedHostBusIn;
                    s_d.phase = PH_ADDR;
                end
            end
            PH_ADDR:
            begin
                if (aleRise)
                begin
                    s_d.phase2 = muxedHostBusIn;
                    if (isIo && (ioAddr == idxPort || (ioAddr == datPort && inRange)))
                    begin
                        s_d.host.claim = 1'b0;
                        s_d.host.claimOe = 1'b1;
                        s_d.host.ready = ~cardWaitN ? 1'b0 : 1'b1;
                        s_d.host.readyOe = 1'b1;
                        s_d.hit = (ioAddr == datPort);
                        s_d.phase = PH_CLAIM;
                    end
                    else
                    begin
                        s_d.phase = PH_IDLE;
                    end
                end
                else if (!addrLatchEnable)
                begin
                    s_d.phase1 = muxedHostBusIn;
                end
            end
            PH_CLAIM:
            begin
                if (!addrLatchEnable)
                begin
                    s_d.host.claimOe = 1'b0;
                    s_d.phase = PH_DATA;
                end
            end
            PH_DATA:
            begin
                s_d.host.ready = cardWaitN;
                if (!commandStrobeN && s_q.phase2[0] && s_q.host.ready
                    && {s_q.phase1[7:2], s_q.phase1[15:8], s_q.phase2[7:6]} == idxPort)
                begin
                    s_d.index = muxedHostBusIn[7:0];
                end
                if (commandStrobeN && s_q.host.ready)
                begin
                    s_d.host.readyOe = 1'b0;
                    s_d.phase = PH_IDLE;
                end
            end
            PH_REQ:
            begin
                if (!commandStrobeN)
                begin
                    s_d.host.claimOe = 1'b0;
                    s_d.host.ready = 1'b0;
                    s_d.host.readyOe = 1'b1;
                    s_d.phase = PH_ACK;
                end
            end
            PH_ACK:
            begin
                s_d.host.ready = 1'b1;
                if (commandStrobeN)
                begin
                    s_d.host.readyOe = 1'b0;
                    s_d.phase = PH_IDLE;
                end
            end
            default:
            begin
                s_d.phase = PH_IDLE;
            end
        endcase
        s_d.host.busOut = 16'h0000;
        s_d.host.busOe = 1'b0;

        // apb slave, one wait-free access phase
        s_d.apb.pready = 1'b0;
        s_d.apb.pslverr = 1'b0;
        if (apbReq.psel && !apbReq.penable)
        begin
            s_d.apb.pready = 1'b1;
            s_d.apb.prdata = 32'h0000_0000;
            case (apbReq.paddr)
                DMA_CTRL_OFFSET:   s_d.apb.prdata = {24'h00_0000, s_q.dmaCtrl};
                STRAP_STAT_OFFSET: s_d.apb.prdata = {24'h00_0000, 3'h0, s_q.straps.secondary,
                                                     s_q.straps.testMode, s_q.straps.range, s_q.straps.valid};
                SLOT_CTRL_OFFSET:  s_d.apb.prdata = {24'h00_0000, s_q.slotCtrl};
                default:           s_d.apb.pslverr = 1'b1;
            endcase
            if (!apbRd)
            begin
                s_d.apb.prdata = 32'h0000_0000;
            end
        end
        if (apbWr && s_q.apb.pready)
        begin
            if (apbReq.paddr == DMA_CTRL_OFFSET)
            begin
                s_d.dmaCtrl = apbReq.pwdata[7:0];
            end
            if (apbReq.paddr == SLOT_CTRL_OFFSET)
            begin
                s_d.slotCtrl = apbReq.pwdata[7:0];
            end
        end

        // power and pull-ups
        s_d.power.supply5 = s_q.slotCtrl[SLOT_SUP5_BIT];
        s_d.power.supply3 = s_q.slotCtrl[SLOT_SUP3_BIT];
        s_d.power.progVoltage = s_q.slotCtrl[SLOT_PROG_BIT];
        s_d.power.progFollows = s_q.slotCtrl[SLOT_PROGVCC_BIT]
                              & (s_q.slotCtrl[SLOT_SUP5_BIT] | s_q.slotCtrl[SLOT_SUP3_BIT]);
        s_d.power.progPullup = 1'b0;
        s_d.power.detectPullup = ~s_q.dmaCtrl[PU_DETECT_BIT];
        s_d.power.memoryPullup = s_q.dmaCtrl[PU_MEMORY_BIT];
        s_d.power.ioPullup = s_q.dmaCtrl[PU_IO_BIT];

        // speaker forward, driven only when enabled
        s_d.spk = cardSpeaker;
        s_d.spkOe = s_q.slotCtrl[SLOT_SPKR_BIT];

        // dma request source
        case (s_q.dmaCtrl[DMA_SEL_LSB +: 2])
            DMA_SRC_INPACK: s_d.dreqN = cardInpackN;
            DMA_SRC_IOIS16: s_d.dreqN = cardIois16N;
            DMA_SRC_SPKR:   s_d.dreqN = cardSpeaker;
            default:        s_d.dreqN = 1'b1;
        endcase

        // terminal count as paired strobes
        s_d.ioWrN = ~(dmaTerminalCount & dmaIsRead);
        s_d.memWrN = ~(dmaTerminalCount & dmaIsRead);
        s_d.ioRdN = ~(dmaTerminalCount & ~dmaIsRead);
        s_d.memRdN = ~(dmaTerminalCount & ~dmaIsRead);
        s_d.cardRst = s_q.slotCtrl[SLOT_CARDRST_BIT];

        if (s_q.straps.testMode && s_q.straps.range == TEST_TRISTATE)
        begin
            s_d.host.claimOe = 1'b0;
            s_d.host.readyOe = 1'b0;
            s_d.spkOe = 1'b0;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            s_q <= '0;
            s_q.phase <= PH_IDLE;
            s_q.dmaCtrl <= DMA_CTRL_RESET;
            s_q.slotCtrl <= SLOT_CTRL_RESET;
            s_q.host.claim <= 1'b1;
            s_q.host.ready <= 1'b1;
            s_q.power.progVoltage <= 1'b1;
            s_q.power.progFollows <= 1'b1;
            s_q.power.progPullup <= 1'b1;
            s_q.power.detectPullup <= 1'b1;
            s_q.dreqN <= 1'b1;
            s_q.memWrN <= 1'b1;
            s_q.memRdN <= 1'b1;
            s_q.ioWrN <= 1'b1;
            s_q.ioRdN <= 1'b1;
        end
        else if (clkEn)
        begin
            s_q <= s_d;
        end
    end

    assign apbRsp = s_q.apb;
    assign hostOut = s_q.host;
    assign powerOut = s_q.power;
    assign speakerToHost = s_q.spk;
    assign speakerToHostOe = s_q.spkOe;
    assign cardDmaRequestN = s_q.dreqN;
    assign cardReset = s_q.cardRst;
    assign cardMemWriteN = s_q.memWrN;
    assign cardMemReadN = s_q.memRdN;
    assign cardIoWriteN = s_q.ioWrN;
    assign cardIoReadN = s_q.ioRdN;
    assign dataPortHit = s_q.hit;
    assign dataPortIndex = s_q.index;
    assign testFunction = s_q.straps.range;
    assign testActive = s_q.straps.testMode;

endmodule

// ---- test/strap_host_checker.sv ----
/*
 * Concurrent checks for the strap, power-control and host-bus block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps

module strap_host_checker
(
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    input  wire strap_pkg::apb_req_t   apbReq,
    input  wire strap_pkg::apb_rsp_t   apbRsp,
    input  wire logic                  addrLatchEnable,
    input  wire logic                  requestPending,
    input  wire logic                  dmaTerminalCount,
    input  wire logic                  dmaIsRead,
    input  wire strap_pkg::host_out_t  hostOut,
    input  wire strap_pkg::power_out_t powerOut,
    input  wire logic                  cardMemWriteN,
    input  wire logic                  cardMemReadN,
    input  wire logic                  cardIoWriteN,
    input  wire logic                  cardIoReadN,
    input  wire logic                  dataPortHit,
    input  wire logic [7:0]            dataPortIndex,
    input  wire logic [1:0]            testFunction,
    input  wire logic                  testActive
);
    import strap_pkg::*;

    default clocking cb @(posedge clk_sys);
    endclocking

    // ****************************************************************
    // properties
    // ****************************************************************
    chk_reset_power: assert property (!rstn |=> powerOut.progVoltage && powerOut.progFollows
        && !powerOut.supply5 && !powerOut.supply3) else $error("power outputs wrong in reset");
    chk_prog_pullup: assert property (powerOut.progPullup |-> !$past(rstn))
        else $error("program pull-up on outside reset");
    chk_claim_cause: assert property (disable iff (!rstn) $fell(hostOut.claim) && hostOut.claimOe
        |-> $past(addrLatchEnable) || $past(requestPending)) else $error("claim without cause");
    chk_claim_hold: assert property (disable iff (!rstn) hostOut.claimOe && !hostOut.claim && addrLatchEnable
        |=> hostOut.claimOe && !hostOut.claim) else $error("claim dropped while latch high");
    chk_tristate_mode: assert property (disable iff (!rstn) testActive && testFunction == TEST_TRISTATE
        |-> !hostOut.claimOe && !hostOut.readyOe) else $error("output driven in tristate test");
    chk_apb_answer: assert property (disable iff (!rstn) apbReq.psel && !apbReq.penable
        |=> apbRsp.pready) else $error("no answer after setup");
    chk_apb_pulse: assert property (disable iff (!rstn) apbRsp.pready |=> !apbRsp.pready)
        else $error("ready held two cycles");
    chk_hit_range: assert property (disable iff (!rstn) dataPortHit
        |-> dataPortIndex[7:6] == testFunction ##1 !dataPortHit) else $error("data port hit out of range");
    chk_tc_read: assert property (disable iff (!rstn) dmaTerminalCount && dmaIsRead
        |-> ##[1:2] !cardMemWriteN && !cardIoWriteN) else $error("terminal count write pair missing");
    chk_tc_write: assert property (disable iff (!rstn) dmaTerminalCount && !dmaIsRead
        |-> ##[1:2] !cardMemReadN && !cardIoReadN) else $error("terminal count read pair missing");

    cover property (hostOut.claimOe && !hostOut.claim && addrLatchEnable);
    cover property (dataPortHit);
    cover property (!addrLatchEnable && hostOut.readyOe && !hostOut.ready);
    cover property (apbRsp.pslverr);
endmodule

bind strap_host_signalling strap_host_checker i_chk
(
    .clk_sys, .rstn, .apbReq, .apbRsp, .addrLatchEnable, .requestPending, .dmaTerminalCount, .dmaIsRead,
    .hostOut, .powerOut, .cardMemWriteN, .cardMemReadN, .cardIoWriteN, .cardIoReadN, .dataPortHit,
    .dataPortIndex, .testFunction, .testActive
);

// ---- test/host_bus_model.sv ----
/*
 * Behavioural host controller on the multiplexed bus.
 * Assumes the device answers on hostOut and runs on clk_sys.
 */
`timescale 1ns/1ps

module host_bus_model
(
    input  wire logic                  clk_sys,
    input  wire strap_pkg::host_out_t  hostOut,
    output logic [15:0]                muxedHostBusIn,
    output logic                       addrLatchEnable,
    output logic                       commandStrobeN
);
    import strap_pkg::*;

    initial
    begin
        muxedHostBusIn = 16'h0000;
        addrLatchEnable = 1'b0;
        commandStrobeN = 1'b1;
    end

    // ****************************************************************
    // bus cycles
    // ****************************************************************
    task automatic cyc(input logic [15:0] a, input logic mem, input logic wr, input logic [7:0] d,
                       output logic hit, output int w);
        logic [15:0] p1;
        p1 = mem ? {a[15:2], 2'b01} : {a[9:2], a[15:10], 2'b10};
        w = 0;
        @(posedge clk_sys);
        muxedHostBusIn <= p1;
        @(posedge clk_sys);
        muxedHostBusIn <= {p1[15:8], a[1:0], p1[5:3], 2'b01, wr};
        addrLatchEnable <= 1'b1;
        repeat (3) @(posedge clk_sys);
        hit = hostOut.claimOe === 1'b1 && hostOut.claim === 1'b0;
        addrLatchEnable <= 1'b0;
        muxedHostBusIn <= wr ? {8'h00, d} : ~muxedHostBusIn;
        commandStrobeN <= 1'b0;
        repeat (2) @(posedge clk_sys);
        while (w < 50 && hostOut.readyOe === 1'b1 && hostOut.ready !== 1'b1)
        begin
            @(posedge clk_sys);
            w++;
        end
        commandStrobeN <= 1'b1;
        muxedHostBusIn <= ~muxedHostBusIn;
        @(posedge clk_sys);
    endtask

    task automatic ack(output logic ok);
        logic seen;
        seen = 1'b0;
        ok = 1'b0;
        for (int i = 0; i < 20 && !seen; i++)
        begin
            @(posedge clk_sys);
            seen = hostOut.claimOe === 1'b1 && hostOut.claim === 1'b0;
        end
        commandStrobeN <= 1'b0;
        for (int i = 0; i < 20 && !ok; i++)
        begin
            @(posedge clk_sys);
            ok = seen && hostOut.readyOe === 1'b1 && hostOut.ready === 1'b0;
        end
        @(posedge clk_sys);
        commandStrobeN <= 1'b1;
    endtask
endmodule

// ---- test/tb_reset_strap_host_signalling.sv ----
/*
 * Self-checking bench for the strap, power-control and host-bus block.
 * Assumes the host model drives the bus side and APB reaches the registers.
 */
`timescale 1ns/1ps

module tb_reset_strap_host_signalling;
    import strap_pkg::*;

    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        clkEn = 1'b1;
    apb_req_t    apbReq = '0;
    apb_rsp_t    apbRsp;
    logic [15:0] muxedHostBusIn;
    logic        addrLatchEnable, commandStrobeN;
    logic        cardWaitN = 1'b1, cardSpeaker = 1'b0, cardInpackN = 1'b1, cardIois16N = 1'b1;
    logic        requestPending = 1'b0, dmaTerminalCount = 1'b0, dmaIsRead = 1'b0;
    logic        strapSupply5 = 1'b0, strapSupply3 = 1'b0, strapProgVoltage = 1'b1, strapProgFollows = 1'b1;
    host_out_t   hostOut;
    power_out_t  powerOut;
    logic        speakerToHost, speakerToHostOe, cardDmaRequestN, cardReset, dataPortHit, testActive;
    logic        cardMemWriteN, cardMemReadN, cardIoWriteN, cardIoReadN, er, hit;
    logic [7:0]  dataPortIndex, idx;
    logic [1:0]  testFunction;
    logic [31:0] seed = 32'h04135E73, rd, v;
    int          mismatches = 0, cmp_count = 0, w;

    always #50 clk_sys = ~clk_sys;

    strap_host_signalling i_dut
    (
        .clk_sys, .rstn, .clkEn, .apbReq, .apbRsp, .muxedHostBusIn, .addrLatchEnable, .commandStrobeN,
        .cardWaitN, .cardSpeaker, .cardInpackN, .cardIois16N, .requestPending, .dmaTerminalCount, .dmaIsRead,
        .strapSupply5, .strapSupply3, .strapProgVoltage, .strapProgFollows, .hostOut, .powerOut,
        .speakerToHost, .speakerToHostOe, .cardDmaRequestN, .cardReset, .cardMemWriteN, .cardMemReadN,
        .cardIoWriteN, .cardIoReadN, .dataPortHit, .dataPortIndex, .testFunction, .testActive
    );

    host_bus_model i_host (.clk_sys, .hostOut, .muxedHostBusIn, .addrLatchEnable, .commandStrobeN);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic test_done();
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        apbReq <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        @(posedge clk_sys);
        while (apbRsp.pready !== 1'b1)
            @(posedge clk_sys);
        r = apbRsp.prdata;
        e = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic rst(input logic [3:0] s);
        @(posedge clk_sys);
        rstn <= 1'b0;
        {strapSupply5, strapSupply3, strapProgVoltage, strapProgFollows} <= s;
        repeat (5) @(posedge clk_sys);
        cmp(32'({powerOut.progVoltage, powerOut.progFollows, powerOut.supply5, powerOut.supply3,
            powerOut.progPullup, powerOut.detectPullup}), 32'h33);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        {strapSupply5, strapSupply3, strapProgVoltage, strapProgFollows} <= ~s;
    endtask

    task automatic host_checks(input logic sec, input logic [1:0] rng);
        logic [15:0] ip;
        ip = sec ? INDEX_PORT_SEC : INDEX_PORT_PRI;
        for (int k = 0; k < 4; k++)
        begin
            v = rnd();
            idx = {k[1:0], v[5:0]};
            i_host.cyc(ip, 1'b0, 1'b1, idx, hit, w);
            cmp(32'(hit), 32'h1);
            cmp(32'(dataPortIndex), 32'(idx));
            i_host.cyc(sec ? DATA_PORT_SEC : DATA_PORT_PRI, 1'b0, 1'b0, 8'h00, hit, w);
            cmp(32'(hit), 32'(k[1:0] == rng));
        end
        i_host.cyc(sec ? DATA_PORT_PRI : DATA_PORT_SEC, 1'b0, 1'b0, 8'h00, hit, w);
        cmp(32'(hit), 32'h0);
        i_host.cyc(ip, 1'b1, 1'b1, 8'h00, hit, w);
        cmp(32'(hit), 32'h0);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        for (int s = 0; s < 16; s++)
        begin
            rst(4'(s));
            apb(1'b0, STRAP_STAT_OFFSET, 32'h0, rd, er);
            cmp(rd, 32'({s[3], s[2], ~s[0], ~s[1], 1'b1}));
            cmp(32'({testActive, testFunction}), 32'({s[2], ~s[0], ~s[1]}));
            if (!s[2])
                host_checks(s[3], {~s[0], ~s[1]});
        end
        rst(4'h3);
        apb(1'b0, DMA_CTRL_OFFSET, 32'h0, rd, er);
        cmp(rd, 32'(DMA_CTRL_RESET));
        apb(1'b0, SLOT_CTRL_OFFSET, 32'h0, rd, er);
        cmp(rd, 32'(SLOT_CTRL_RESET));
        apb(1'b1, STRAP_STAT_OFFSET, 32'hFFFFFFFF, rd, er);
        apb(1'b0, STRAP_STAT_OFFSET, 32'h0, rd, er);
        cmp(rd, 32'h1);
        apb(1'b0, 12'h00C, 32'h0, rd, er);
        cmp({rd[30:0], er}, 32'h1);
        for (int m = 0; m < 8; m++)
        begin
            v = rnd();
            v[7:6] = m[1:0];
            apb(1'b1, DMA_CTRL_OFFSET, v, rd, er);
            {cardInpackN, cardIois16N, cardSpeaker} <= v[10:8];
            apb(1'b0, DMA_CTRL_OFFSET, 32'h0, rd, er);
            cmp(rd & 32'hFFFFFFF8, {24'h0, v[7:3], 3'h0});
            cmp(32'({powerOut.detectPullup, powerOut.memoryPullup, powerOut.ioPullup}),
                32'({~v[5], v[4], v[3]}));
            cmp(32'(cardDmaRequestN), 32'(m[1:0] == 2'h0 ? 1'b1 : m[1:0] == 2'h1 ? v[10] :
                m[1:0] == 2'h2 ? v[9] : v[8]));
        end
        for (int t = 0; t < 2; t++)
        begin
            dmaIsRead <= t[0];
            dmaTerminalCount <= 1'b1;
            @(posedge clk_sys);
            dmaTerminalCount <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        for (int n = 0; n < 6; n++)
        begin
            v = rnd();
            v[5] = n[0];
            apb(1'b1, SLOT_CTRL_OFFSET, v, rd, er);
            apb(1'b0, SLOT_CTRL_OFFSET, 32'h0, rd, er);
            cmp(rd & 32'h3F, v & 32'h3F);
            cmp(32'({powerOut.progVoltage, powerOut.progFollows, powerOut.supply5, powerOut.supply3, cardReset}),
                32'({v[0], v[1] & (v[2] | v[3]), v[2], v[3], v[4]}));
            cmp(32'({speakerToHost, speakerToHostOe}), 32'({cardSpeaker, n[0]}));
        end
        i_host.cyc(INDEX_PORT_PRI, 1'b0, 1'b1, 8'h05, hit, w);
        cardWaitN <= 1'b0;
        fork
            begin
                repeat (16) @(posedge clk_sys);
                cardWaitN <= 1'b1;
            end
        join_none
        i_host.cyc(DATA_PORT_PRI, 1'b0, 1'b0, 8'h00, hit, w);
        cmp(32'(w > 3), 32'h1);
        requestPending <= 1'b1;
        i_host.ack(hit);
        requestPending <= 1'b0;
        cmp(32'(hit), 32'h1);
        repeat (10) @(posedge clk_sys);
        test_done();
    end

    initial
    begin
        #2000000;
        mismatches++;
        test_done();
    end
endmodule
